// ===== logic/irr_receiver.sv
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Full byte copies shift register to holding
// - Holding register content undefined until transfer
// - Three-bit counter of bits in byte
// - Counter increments on each decoded bit
// - Counter cleared when receiver stopped
// - Guide formats clear counter on guide
// - Guideless formats clear counter on rise
// - Counter and suspend bits are read-only
// - PPM prescaler counts four to thirty-two
// - Manchester prescaler counts two to sixteen
// - End of frame sets suspend, halts
// - Suspended receiver ignores all input
// - Shift register read resumes reception
// - Suspend cleared when receiver stopped
// - Guide prescale ignored in guideless formats
// - Guide bounds ignored in guideless formats
// - Data-0 register holds upper, lower nibbles
// - Data-1 register holds upper, lower nibbles
// - Bit count stays readable after end
// - Format select encodes five formats
// - Bounds are five bits with extension
// - Accept width in lower+1 to upper, reject upper+1
// - Run bit starts and stops reception
module irr_receiver (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ir_in,
    input wire logic sub_clk_in,
    input wire logic [17:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [17:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // All state of the block
    typedef struct packed {
        logic ir_s1; // Input synchroniser, first stage
        logic ir_s2; // Input synchroniser, second stage
        logic ir_prev; // Previous level for edge detection
        logic sub_s1; // Subclock synchroniser, first stage
        logic sub_s2; // Subclock synchroniser, second stage
        logic sub_prev; // Previous subclock level
        logic [6:0] base_cnt; // Base period divider
        logic [4:0] pre_cnt; // Phase prescaler
        logic [5:0] wcnt; // Pulse width in phase ticks
        irr_pkg::irr_state_e st; // Receiver sequencing
        logic half; // Manchester boundary edge seen
        logic [7:0] ctrl; // Run, format, polarity, clock select
        logic gok; // Guide received
        logic err; // Data error
        logic bful; // Byte transfer flag
        logic rend; // End of reception
        logic [3:0] ien; // Enable bits, stored only
        logic [7:0] shift; // Receive shift register
        logic [7:0] holding; // Receive byte holding register
        logic [3:0] psel; // Guide and data prescaler selects
        logic suspend; // Suspend flag
        logic [2:0] bitcnt;
        logic [7:0] gpw; // Guide width bounds
        logic [7:0] d0w; // Data-0 width bounds
        logic [7:0] d1w; // Data-1 width bounds
        logic dir; // Shift direction, 1 = MSB first
        logic [5:0] hi; // Bit 4 of each bound
        logic awready; // Bus write address ready
        logic wready; // Bus write data ready
        logic aw_ok; // Write address latched
        logic [15:0] aw_idx; // Latched write index
        logic w_ok; // Write data latched
        logic [7:0] wd; // Latched write data
        logic wbyte; // Low byte lane enabled
        logic bvalid; // Write response pending
        logic [1:0] bresp; // Write response code
        logic arready; // Bus read address ready
        logic rvalid; // Read data pending
        logic [7:0] rdata; // Read data
        logic [1:0] rresp; // Read response code
    } irr_s;

    irr_s s; // Registered state
    irr_s n; // Next state

    // Bounds widen to thresholds of (value + 1) ticks
    function automatic logic [5:0] lim(input logic [4:0] b);
        lim = {1'b0, b} + 6'h01;
    endfunction

    // Outputs come straight from the state register
    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rdata = {24'h000000, s.rdata};

    logic lvl; // Polarity-corrected input level
    logic prev_lvl; // Polarity-corrected previous level
    logic rise; // Corrected rising edge
    logic fall; // Corrected falling edge
    logic [2:0] fmt; // Selected format
    logic manch; // Manchester format in use
    logic guided; // Format with a guide pulse
    logic [2:0] cksel; // Reference clock select
    logic [7:0] base_last; // Last count of the base divider
    logic base_tick; // One base period elapsed
    logic [1:0] sel; // Prescaler select of the current phase
    logic [5:0] pre_last; // Last count of the prescaler
    logic phase_tick; // One phase tick elapsed
    logic [4:0] glo, ghi, zlo, zhi, olo, ohi; // Five-bit bounds
    logic gwin, zwin, owin; // Width inside a window
    logic ref_edge; // Edge that closes a measured pulse
    logic emit; // A data bit was decoded
    logic bitv; // Value of the decoded bit
    logic [7:0] newsh; // Shift register with the new bit
    logic [15:0] ar_idx; // Read index
    logic wmap; // Write index is mapped

    // Next-state logic for bus, timing and receiver
    always_comb begin
        n = s;
        emit = 1'b0;
        bitv = 1'b0;
        ref_edge = 1'b0; // Idle and hold close no pulse
        // Two-flop synchronisers; only the second stage is looked at
        n.ir_s1 = ir_in;
        n.ir_s2 = s.ir_s1;
        n.ir_prev = s.ir_s2;
        n.sub_s1 = sub_clk_in;
        n.sub_s2 = s.sub_s1;
        n.sub_prev = s.sub_s2;
        lvl = s.ir_s2 ^ s.ctrl[irr_pkg::CTRL_INV];
        prev_lvl = s.ir_prev ^ s.ctrl[irr_pkg::CTRL_INV];
        rise = lvl & ~prev_lvl;
        fall = ~lvl & prev_lvl;
        fmt = s.ctrl[irr_pkg::CTRL_FMT_LSB +: 3];
        manch = (fmt == irr_pkg::FMT_NONE_MAN) || (fmt == irr_pkg::FMT_CLK_MAN);
        guided = (fmt == irr_pkg::FMT_HALF_PPM) ||
                 (fmt == irr_pkg::FMT_CLK_PPM) || (fmt == irr_pkg::FMT_CLK_MAN);
        cksel = s.ctrl[2:0];

        // Base period: 4..128 cycles, one cycle, or a subclock edge
        base_last = (irr_pkg::BASE_MIN << cksel) - 8'h01;
        if (cksel == irr_pkg::CK_SUB) begin
            base_tick = s.sub_s2 & ~s.sub_prev;
        end else if (cksel == irr_pkg::CK_ONE) begin
            base_tick = 1'b1;
        end else begin
            base_tick = ({1'b0, s.base_cnt} >= base_last);
        end
        n.base_cnt = base_tick ? 7'h00 : s.base_cnt + 7'h01;

        // Guide select only applies while a guide is measured
        sel = (s.st == irr_pkg::ST_GUIDE) ? s.psel[3:2] : s.psel[1:0];
        if (manch) begin
            pre_last = (irr_pkg::PRE_MAN_MIN << sel) - 6'h01;
        end else begin
            pre_last = (irr_pkg::PRE_PPM_MIN << sel) - 6'h01;
        end
        phase_tick = base_tick && ({1'b0, s.pre_cnt} >= pre_last);
        if (base_tick) begin
            n.pre_cnt = phase_tick ? 5'h00 : s.pre_cnt + 5'h01;
        end
        // Width saturates so a long gap never wraps into a window
        if (phase_tick && s.wcnt != irr_pkg::WIDTH_MAX) begin
            n.wcnt = s.wcnt + 6'h01;
        end

        // Bounds: nibble from the width register, bit 4 from extension
        glo = {s.hi[0], s.gpw[3:0]};
        ghi = {s.hi[1], s.gpw[7:4]};
        zlo = {s.hi[2], s.d0w[3:0]};
        zhi = {s.hi[3], s.d0w[7:4]};
        olo = {s.hi[4], s.d1w[3:0]};
        ohi = {s.hi[5], s.d1w[7:4]};
        gwin = (s.wcnt >= lim(glo)) && (s.wcnt < lim(ghi));
        zwin = (s.wcnt >= lim(zlo)) && (s.wcnt < lim(zhi));
        owin = (s.wcnt >= lim(olo)) && (s.wcnt < lim(ohi));

        // Bus write channel; applied before hardware sets so a set wins
        if (s_axi_awvalid && s.awready) begin
            n.aw_ok = 1'b1;
            n.aw_idx = s_axi_awaddr[17:2];
            n.awready = 1'b0;
        end
        if (s_axi_wvalid && s.wready) begin
            n.w_ok = 1'b1;
            n.wd = s_axi_wdata[7:0];
            n.wbyte = s_axi_wstrb[0];
            n.wready = 1'b0;
        end
        wmap = 1'b1;
        if (s.aw_ok && s.w_ok && !s.bvalid) begin
            unique case (s.aw_idx)
                irr_pkg::IDX_CTRL: begin
                    if (s.wbyte) n.ctrl = s.wd;
                end
                irr_pkg::IDX_FLAGS: begin
                    // Flags clear on writing 0, writing 1 leaves them
                    if (s.wbyte) begin
                        n.gok = s.gok & s.wd[irr_pkg::FLG_GOK];
                        n.err = s.err & s.wd[irr_pkg::FLG_ERR];
                        n.bful = s.bful & s.wd[irr_pkg::FLG_BFUL];
                        n.rend = s.rend & s.wd[irr_pkg::FLG_REND];
                        n.ien = {s.wd[6], s.wd[4], s.wd[2], s.wd[0]};
                    end
                end
                irr_pkg::IDX_CTPR: begin
                    if (s.wbyte) n.psel = s.wd[7:4];
                end
                irr_pkg::IDX_GPW: begin
                    if (s.wbyte) n.gpw = s.wd;
                end
                irr_pkg::IDX_D0W: begin
                    if (s.wbyte) n.d0w = s.wd;
                end
                irr_pkg::IDX_D1W: begin
                    if (s.wbyte) n.d1w = s.wd;
                end
                irr_pkg::IDX_XHW: begin
                    if (s.wbyte) begin
                        n.dir = s.wd[7];
                        n.hi = s.wd[5:0];
                    end
                end
                // Read-only registers accept the write and keep their value
                irr_pkg::IDX_SHIFT, irr_pkg::IDX_HOLDING: begin
                end
                default: wmap = 1'b0;
            endcase
            n.bvalid = 1'b1;
            n.bresp = wmap ? irr_pkg::RESP_OKAY : irr_pkg::RESP_SLVERR;
            n.aw_ok = 1'b0;
            n.w_ok = 1'b0;
        end
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
            n.awready = 1'b1;
            n.wready = 1'b1;
        end

        // Receiver sequencing
        unique case (s.st)
            irr_pkg::ST_IDLE: begin
                if (rise) begin
                    n.wcnt = 6'h00;
                    n.pre_cnt = 5'h00;
                    n.half = 1'b0;
                    if (guided) begin
                        n.st = irr_pkg::ST_GUIDE;
                    end else begin
                        // No guide: the first rise opens the frame
                        n.shift = 8'h00;
                        n.bitcnt = 3'h0;
                        n.st = irr_pkg::ST_DATA;
                    end
                end
            end
            irr_pkg::ST_GUIDE: begin
                // Half-clock guide ends on its fall, clock guide on a rise
                ref_edge = (fmt == irr_pkg::FMT_HALF_PPM) ? fall : rise;
                if (ref_edge) begin
                    n.wcnt = 6'h00;
                    n.pre_cnt = 5'h00;
                    if (gwin) begin
                        n.gok = 1'b1;
                        n.shift = 8'h00;
                        n.bitcnt = 3'h0;
                        n.st = irr_pkg::ST_DATA;
                    end else begin
                        n.st = irr_pkg::ST_IDLE;
                    end
                end else if (s.wcnt >= lim(ghi)) begin
                    n.st = irr_pkg::ST_IDLE;
                end
            end
            irr_pkg::ST_DATA: begin
                if (manch) begin
                    ref_edge = rise | fall;
                end else if (fmt == irr_pkg::FMT_HALF_PPM) begin
                    ref_edge = fall;
                end else begin
                    ref_edge = rise;
                end
                if (ref_edge) begin
                    n.wcnt = 6'h00;
                    n.pre_cnt = 5'h00;
                    if (!manch && zwin) begin
                        emit = 1'b1;
                    end else if (!manch && owin) begin
                        emit = 1'b1;
                        bitv = 1'b1;
                    end else if (manch && owin) begin
                        // Full-bit spacing: this is a mid-bit edge
                        emit = 1'b1;
                        bitv = lvl;
                        n.half = 1'b0;
                    end else if (manch && zwin) begin
                        // Half-bit spacing: every second one is mid-bit
                        emit = s.half;
                        bitv = lvl;
                        n.half = ~s.half;
                    end else begin
                        n.err = 1'b1;
                        n.st = irr_pkg::ST_IDLE;
                    end
                end else if (s.wcnt >= lim(ohi)) begin
                    // Silence past the data-1 bound ends the frame
                    n.rend = 1'b1;
                    n.suspend = 1'b1;
                    n.st = irr_pkg::ST_HOLD;
                end
            end
            irr_pkg::ST_HOLD: begin
                n.wcnt = 6'h00;
            end
        endcase

        // Decoded bit enters the shift register and the counter
        newsh = s.dir ? {s.shift[6:0], bitv} : {bitv, s.shift[7:1]};
        if (emit) begin
            if (s.bitcnt == irr_pkg::BITS_LAST) begin
                n.holding = newsh;
                n.shift = 8'h00;
                n.bful = 1'b1;
                n.bitcnt = 3'h0;
            end else begin
                n.shift = newsh;
                n.bitcnt = s.bitcnt + 3'h1;
            end
        end

        // Bus read channel; reading the shift register resumes
        ar_idx = s_axi_araddr[17:2];
        if (s_axi_arvalid && s.arready) begin
            n.arready = 1'b0;
            n.rvalid = 1'b1;
            n.rresp = irr_pkg::RESP_OKAY;
            unique case (ar_idx)
                irr_pkg::IDX_CTRL: n.rdata = s.ctrl;
                irr_pkg::IDX_FLAGS: n.rdata = {s.gok, s.ien[3], s.err,
                    s.ien[2], s.bful, s.ien[1], s.rend, s.ien[0]};
                irr_pkg::IDX_SHIFT: begin
                    n.rdata = s.shift;
                    if (s.st == irr_pkg::ST_HOLD) begin
                        n.suspend = 1'b0;
                        n.st = irr_pkg::ST_IDLE;
                    end
                end
                irr_pkg::IDX_HOLDING: n.rdata = s.holding;
                irr_pkg::IDX_CTPR: n.rdata = {s.psel, s.suspend, s.bitcnt};
                irr_pkg::IDX_GPW: n.rdata = s.gpw;
                irr_pkg::IDX_D0W: n.rdata = s.d0w;
                irr_pkg::IDX_D1W: n.rdata = s.d1w;
                irr_pkg::IDX_XHW: n.rdata = {s.dir, 1'b0, s.hi};
                default: begin
                    n.rdata = 8'h00;
                    n.rresp = irr_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
            n.arready = 1'b1;
        end

        // Stopped receiver: sequencing, bit, width and prescale counters held clear; the base divider keeps running
        if (!s.ctrl[irr_pkg::CTRL_RUN]) begin
            n.st = irr_pkg::ST_IDLE;
            n.bitcnt = 3'h0;
            n.suspend = 1'b0;
            n.shift = 8'h00;
            n.half = 1'b0;
            n.wcnt = 6'h00;
            n.pre_cnt = 5'h00;
        end

        // Synchronous reset; ready signals come up high
        if (!aresetn) begin
            n = '0;
            n.ctrl = irr_pkg::RST_REG;
            n.awready = 1'b1;
            n.wready = 1'b1;
            n.arready = 1'b1;
        end
    end

    // Single state register
    always_ff @(posedge aclk) begin
        s <= n;
    end

endmodule // irr_receiver

`default_nettype wire

// ===== logic/irr_pkg.sv
package irr_pkg;

    // Register indices; byte address on the bus is four times the index
    localparam logic [15:0] IDX_CTRL = 16'hFE27;
    localparam logic [15:0] IDX_FLAGS = 16'hFE28;
    localparam logic [15:0] IDX_SHIFT = 16'hFE29;
    localparam logic [15:0] IDX_HOLDING = 16'hFE2A;
    localparam logic [15:0] IDX_CTPR = 16'hFE2B;
    localparam logic [15:0] IDX_GPW = 16'hFE2C;
    localparam logic [15:0] IDX_D0W = 16'hFE2D;
    localparam logic [15:0] IDX_D1W = 16'hFE2E;
    localparam logic [15:0] IDX_XHW = 16'hFE2F;

    // Control register fields
    localparam int CTRL_RUN = 7;
    localparam int CTRL_FMT_LSB = 4;
    localparam int CTRL_INV = 3;

    // Flag register fields
    localparam int FLG_GOK = 7;
    localparam int FLG_ERR = 5;
    localparam int FLG_BFUL = 3;
    localparam int FLG_REND = 1;

    // Format codes
    localparam logic [2:0] FMT_HALF_PPM = 3'h0;
    localparam logic [2:0] FMT_CLK_PPM = 3'h1;
    localparam logic [2:0] FMT_NONE_PPM = 3'h2;
    localparam logic [2:0] FMT_NONE_MAN = 3'h3;
    localparam logic [2:0] FMT_CLK_MAN = 3'h4;

    // Reference clock selects with special meaning
    localparam logic [2:0] CK_SUB = 3'h6;
    localparam logic [2:0] CK_ONE = 3'h7;

    // Base divider and prescaler counts
    localparam logic [7:0] BASE_MIN = 8'h04;
    localparam logic [5:0] PRE_PPM_MIN = 6'h04;
    localparam logic [5:0] PRE_MAN_MIN = 6'h02;
    localparam logic [5:0] WIDTH_MAX = 6'h3F;
    localparam logic [2:0] BITS_LAST = 3'h7;

    // Reset values
    localparam logic [7:0] RST_REG = 8'h00;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Receiver sequencing
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_GUIDE = 2'b01,
        ST_DATA = 2'b10,
        ST_HOLD = 2'b11
    } irr_state_e;

endpackage

// ===== test/irr_ir_source.sv
`timescale 1ns/10ps
`default_nettype none
// Demodulated remote-control line: idles low, marks are rise to rise
module irr_ir_source (
    input wire logic aclk,
    output logic ir_line
);
    initial ir_line = 1'b0; // Idle space level before any frame
    // A mark a quarter period long, then space up to the next rise
    task automatic mark(input int period);
        @(posedge aclk);
        ir_line <= 1'b1;
        repeat (period / 4) @(posedge aclk);
        ir_line <= 1'b0;
        repeat (period - period / 4 - 1) @(posedge aclk);
    endtask
endmodule // irr_ir_source
`default_nettype wire

// ===== test/irr_receiver_properties.sv
`timescale 1ns/10ps
`default_nettype none
// Register-bus watch on the receiver, from its ports alone
module irr_receiver_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ir_in,
    input wire logic sub_clk_in,
    input wire logic [17:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [17:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [15:0] ar_idx; // Index of the read in flight
    logic [15:0] aw_idx; // Index of the write in flight
    logic [8:0] wd; // Low strobe and low data byte
    logic run_off; // Receiver known to be stopped
    logic [3:0] pre_hi; // Prescale selects last written
    logic ar_map; // Read lands in the register block
    logic aw_map; // Write lands in the register block
    logic b_done; // A strobed write was answered
    assign ar_map = ar_idx >= irr_pkg::IDX_CTRL
        && ar_idx <= irr_pkg::IDX_XHW;
    assign aw_map = aw_idx >= irr_pkg::IDX_CTRL
        && aw_idx <= irr_pkg::IDX_XHW;
    assign b_done = s_axi_bvalid && s_axi_bready && wd[8];
    // A write counts only once answered, so a refused one never does
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_idx <= 16'h0000;
            aw_idx <= 16'h0000;
            wd <= 9'h000;
            run_off <= 1'b1;
            pre_hi <= 4'h0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) ar_idx <= s_axi_araddr[17:2];
            if (s_axi_awvalid && s_axi_awready) aw_idx <= s_axi_awaddr[17:2];
            if (s_axi_wvalid && s_axi_wready)
                wd <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
            if (b_done && aw_idx == irr_pkg::IDX_CTRL) run_off <= !wd[7];
            if (b_done && aw_idx == irr_pkg::IDX_CTPR) pre_hi <= wd[7:4];
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data above the byte is set");
    read_resp_a: assert property (s_axi_rvalid |-> s_axi_rresp == (ar_map ? irr_pkg::RESP_OKAY : irr_pkg::RESP_SLVERR))
        else $error("read response code wrong");
    write_resp_a: assert property (s_axi_bvalid |-> s_axi_bresp == (aw_map ? irr_pkg::RESP_OKAY : irr_pkg::RESP_SLVERR))
        else $error("write response code wrong");
    unmapped_zero_a: assert property (s_axi_rvalid && !ar_map |-> s_axi_rdata == 32'h00000000)
        else $error("unmapped read returned data");
    stop_clear_a: assert property (s_axi_rvalid && ar_idx == irr_pkg::IDX_CTPR && run_off |-> s_axi_rdata[3:0] == 4'h0)
        else $error("count or suspend set while stopped");
    ctpr_select_a: assert property (s_axi_rvalid && ar_idx == irr_pkg::IDX_CTPR |-> s_axi_rdata[7:4] == pre_hi)
        else $error("prescale selects lost");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered next cycle");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_awready ##1 s_axi_bvalid)
        else $error("write not answered in two cycles");
endmodule // irr_receiver_properties
bind irr_receiver irr_receiver_properties chk (.*);
`default_nettype wire

// ===== test/irr_receiver_bench.sv
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench: bus tasks, an IR source, a task per scenario
module irr_receiver_bench;
    logic aclk = 1'b0; // 200 MHz system clock
    logic aresetn = 1'b0; // Low for the first ten cycles
    logic ir_in; // Driven by the IR source
    logic sub_clk_in = 1'b0; // Tied: the base tick is one cycle here
    logic [17:0] s_axi_awaddr = 18'h00000;
    logic [17:0] s_axi_araddr = 18'h00000;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int error_cnt = 0; // Mismatches seen
    int checks_done = 0; // Comparisons made
    int cycles = 0; // Guard against a hang
    irr_receiver uut (.*);
    irr_ir_source src (.aclk(aclk), .ir_line(ir_in));
    initial forever #2.5 aclk = ~aclk;
    // The whole frame set needs about a sixth of this
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 40000) begin
            error_cnt++;
            final_report;
        end
    end
    task final_report;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task check(input string what, input logic [7:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [15:0] idx, input logic [7:0] dat,
                      output logic [1:0] r);
        logic a;
        logic w;
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h000000, dat};
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        a = 1'b1;
        w = 1'b1;
        forever begin
            @(posedge aclk);
            if (a && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (a && s_axi_awready) a = 1'b0;
            if (w && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (w && s_axi_wready) w = 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rd(input logic [15:0] idx, output logic [7:0] d,
                      output logic [1:0] r);
        logic a;
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        a = 1'b1;
        forever begin
            @(posedge aclk);
            if (a && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (a && s_axi_arready) a = 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata[7:0];
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rc(input logic [15:0] idx, input logic [7:0] exp,
                      input string what);
        logic [7:0] d;
        logic [1:0] r;
        rd(idx, d, r);
        check(what, d, exp);
    endtask
    task automatic test_regs;
        logic [1:0] r;
        logic [7:0] d;
        for (int i = 0; i < 4; i++)
            rc(irr_pkg::IDX_CTPR + 16'(i), irr_pkg::RST_REG, "reset");
        wr(irr_pkg::IDX_CTPR, 8'hFF, r);
        rc(irr_pkg::IDX_CTPR, 8'hF0, "ctpr low bits");
        wr(irr_pkg::IDX_D1W, 8'hC3, r);
        rc(irr_pkg::IDX_D1W, 8'hC3, "one bounds");
        wr(irr_pkg::IDX_HOLDING, 8'h77, r);
        check("holding write", 8'(r), 8'(irr_pkg::RESP_OKAY));
        wr(16'h0100, 8'h11, r);
        check("bad write", 8'(r), 8'(irr_pkg::RESP_SLVERR));
        rd(16'h0100, d, r);
        check("bad read", 8'(r), 8'(irr_pkg::RESP_SLVERR));
        $display("register test done");
    endtask
    // Ten bits: one byte plus two left over, then marks while held
    task automatic test_frame(input logic [1:0] sel, input logic [2:0] fmt);
        int tick;
        logic [9:0] pat;
        logic [1:0] r;
        logic [7:0] d;
        tick = 4 << sel;
        pat = 10'h1A6;
        wr(irr_pkg::IDX_FLAGS, 8'h00, r);
        wr(irr_pkg::IDX_D0W, 8'h51, r);
        wr(irr_pkg::IDX_D1W, 8'hB7, r);
        wr(irr_pkg::IDX_GPW, 8'h73, r);
        wr(irr_pkg::IDX_CTPR, {2'b11, sel, 4'hF}, r);
        wr(irr_pkg::IDX_CTRL, {1'b1, fmt, 4'h7}, r);
        // Guide of six ticks at the guide select's count of 32
        if (fmt == irr_pkg::FMT_CLK_PPM) src.mark(192);
        for (int i = 0; i < 10; i++) src.mark((pat[i] ? 10 : 4) * tick);
        src.mark(20 * tick); // Stop edge; the silence after it ends the frame
        for (int i = 0; i < 3; i++) src.mark(4 * tick);
        rd(irr_pkg::IDX_FLAGS, d, r);
        check("byte flag", {7'h00, d[3]}, 8'h01);
        rc(irr_pkg::IDX_HOLDING, 8'hA6, "holding");
        rc(irr_pkg::IDX_CTPR, {2'b11, sel, 4'hA}, "held count");
        rd(irr_pkg::IDX_SHIFT, d, r);
        check("shift left over", d, 8'h40);
        rd(irr_pkg::IDX_CTPR, d, r);
        check("resumed", {7'h00, d[3]}, 8'h00);
        wr(irr_pkg::IDX_CTRL, 8'h00, r);
        rc(irr_pkg::IDX_CTPR, {2'b11, sel, 4'h0}, "stopped");
        $display("frame test select %0d format %0d done", sel, fmt);
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        test_regs;
        // Guideless at every data select, then one guided frame
        for (int s = 0; s < 5; s++)
            test_frame(2'(s), (s < 4) ? irr_pkg::FMT_NONE_PPM
                                      : irr_pkg::FMT_CLK_PPM);
        final_report;
    end
endmodule // irr_receiver_bench
`default_nettype wire
